/* pkg/adcs_pkg.sv */
// Constants for the A/D conversion timing sequencer
package adcs_pkg;

  // One sys_clk period spans two half-CPU-clock units
  localparam int TCL_PER_CYCLE = 2;

  // Conversion step lengths in half-CPU-clock units, per select code
  localparam int CC_TCL_FAST = 24;
  localparam int CC_TCL_MID  = 48;
  localparam int CC_TCL_SLOW = 96;

  // Result load tail in half-CPU-clock units
  localparam int LOAD_TCL = 4;

  // Derived cycle counts
  localparam int CC_CYC_FAST = CC_TCL_FAST / TCL_PER_CYCLE;
  localparam int CC_CYC_MID  = CC_TCL_MID / TCL_PER_CYCLE;
  localparam int CC_CYC_SLOW = CC_TCL_SLOW / TCL_PER_CYCLE;
  localparam int LOAD_CYC    = LOAD_TCL / TCL_PER_CYCLE;

  // Sequence shape
  localparam int SAMPLE_SC_PERIODS = 2;
  localparam int RES_BITS          = 10;
  localparam int EQ_STEPS          = 4;
  localparam int CNT_W             = 12;
  localparam int STEP_W            = 4;

  // Control register layout: both select fields in the upper four bits
  localparam int CTRL_W  = 16;
  localparam int SEL_W   = 2;
  localparam int CCS_LSB = 14;
  localparam int SCS_LSB = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

  // Conversion step clock select codes (2'h1 is reserved)
  localparam logic [SEL_W-1:0] CCS_FAST = 2'h0;
  localparam logic [SEL_W-1:0] CCS_SLOW = 2'h2;
  localparam logic [SEL_W-1:0] CCS_MID  = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_BITS,
    ST_EQUAL,
    ST_LOAD
  } adcs_state_t;

endpackage

/* core/adcs_conv_timing.sv */
// Sequencer for sample, bit-decision, equalizing and result load of the SAR converter
`timescale 1ns/1ps

module adcs_conv_timing
  import adcs_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                ctrl_wr,
  input  wire logic [CTRL_W-1:0]   ctrl_wdata,
  input  wire logic                conv_start,
  input  wire logic                cmp_below_pin,
  input  wire logic                below_gnd_pin,
  input  wire logic                above_ref_pin,
  output logic      [CTRL_W-1:0]   converter_control_reg,
  output logic                     conv_busy,
  output logic                     sampling,
  output logic      [RES_BITS-1:0] dac_code,
  output logic      [RES_BITS-1:0] result,
  output logic                     result_valid
);

  // step length per code
  // Step length in cycles for a step clock select code
  function automatic logic [CNT_W-1:0] cc_cycles(input logic [SEL_W-1:0] sel);
    case (sel)
      CCS_MID:  cc_cycles = CNT_W'(CC_CYC_MID);
      CCS_SLOW: cc_cycles = CNT_W'(CC_CYC_SLOW);
      // The reserved code falls back to the fastest step
      default:  cc_cycles = CNT_W'(CC_CYC_FAST);
    endcase
  endfunction

  adcs_state_t         state;
  adcs_state_t         next_state;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    next_cnt;
  logic [STEP_W-1:0]   step_idx;
  logic [STEP_W-1:0]   next_step_idx;
  logic [SEL_W-1:0]    lat_ccs;
  logic [SEL_W-1:0]    lat_scs;
  logic [RES_BITS-1:0] sar_mask;
  logic [RES_BITS-1:0] next_sar_mask;
  logic [RES_BITS-1:0] next_dac_code;
  logic                clamp_lo;
  logic                clamp_hi;
  logic [2:0]          sync_meta;
  logic [2:0]          sync_q;

  // Field decode and phase lengths from the latched selects, except the sampling count loaded at start, which reads the fields
  wire logic [SEL_W-1:0] ccs_field  = converter_control_reg[CCS_LSB +: SEL_W];
  wire logic [SEL_W-1:0] scs_field  = converter_control_reg[SCS_LSB +: SEL_W];
  wire logic [CNT_W-1:0] step_len   = cc_cycles(lat_ccs);
  wire logic [CNT_W-1:0] sample_len = CNT_W'(SAMPLE_SC_PERIODS) * (step_len << lat_scs);
  wire logic             take       = (state == ST_IDLE) && conv_start;
  wire logic             last_cyc   = (cnt == '0);
  wire logic             cmp_below  = sync_q[0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      converter_control_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      converter_control_reg <= ctrl_wdata;
    end
  end

  // Comparator and range flags are analog-side levels, so two flops first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta <= 3'h0;
      sync_q    <= 3'h0;
    end else begin
      sync_meta <= {above_ref_pin, below_gnd_pin, cmp_below_pin};
      sync_q    <= sync_meta;
    end
  end

  // phase sequencing on cycle counters; each unit pair is one cycle
  always_comb begin
    next_state    = state;
    next_cnt      = last_cyc ? cnt : cnt - CNT_W'(1);
    next_step_idx = step_idx;
    next_sar_mask = sar_mask;
    next_dac_code = dac_code;
    case (state)
      ST_IDLE: begin
        if (conv_start) begin
          next_state = ST_SAMPLE;
          next_cnt   = CNT_W'(SAMPLE_SC_PERIODS) * (cc_cycles(ccs_field) << scs_field)
                       - CNT_W'(1);
        end
      end
      ST_SAMPLE: begin
        if (last_cyc) begin
          next_state    = ST_BITS;
          next_cnt      = step_len - CNT_W'(1);
          next_step_idx = '0;
          next_sar_mask = {1'b1, {(RES_BITS-1){1'b0}}};
          next_dac_code = {1'b1, {(RES_BITS-1){1'b0}}};
        end
      end
      ST_BITS: begin
        if (last_cyc) begin
          // one decision per step, MSB first
          next_sar_mask = sar_mask >> 1;
          next_dac_code = (dac_code & ~(cmp_below ? sar_mask : '0)) | (sar_mask >> 1);
          next_cnt      = step_len - CNT_W'(1);
          next_step_idx = step_idx + STEP_W'(1);
          if (step_idx == STEP_W'(RES_BITS - 1)) begin
            next_state    = ST_EQUAL;
            next_step_idx = '0;
          end
        end
      end
      ST_EQUAL: begin
        if (last_cyc) begin
          next_cnt      = step_len - CNT_W'(1);
          next_step_idx = step_idx + STEP_W'(1);
          if (step_idx == STEP_W'(EQ_STEPS - 1)) begin
            next_state = ST_LOAD;
            next_cnt   = CNT_W'(LOAD_CYC - 1);
          end
        end
      end
      ST_LOAD: begin
        if (last_cyc) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and registered status outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      step_idx  <= '0;
      sar_mask  <= '0;
      dac_code  <= '0;
      conv_busy <= 1'b0;
      sampling  <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      step_idx  <= next_step_idx;
      sar_mask  <= next_sar_mask;
      dac_code  <= next_dac_code;
      conv_busy <= (next_state != ST_IDLE);
      sampling  <= (next_state == ST_SAMPLE);
    end
  end

  // selects latched at start so a mid-conversion write cannot stretch it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lat_ccs <= CCS_FAST;
      lat_scs <= '0;
    end else if (take) begin
      lat_ccs <= ccs_field;
      lat_scs <= scs_field;
    end
  end

  // range flags frozen at the end of sampling
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clamp_lo <= 1'b0;
      clamp_hi <= 1'b0;
    end else if (state == ST_SAMPLE && last_cyc) begin
      clamp_lo <= sync_q[1];
      clamp_hi <= sync_q[2];
    end
  end

  // result load on the final cycle; clamps override the code
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= (state == ST_LOAD) && last_cyc;
      if (state == ST_LOAD && last_cyc) begin
        result <= clamp_lo ? '0 : (clamp_hi ? '1 : dac_code);
      end
    end
  end

  // Checking helpers: cycles since start, sampling run, equalize run
  logic [CNT_W-1:0] chk_total;
  logic [CNT_W-1:0] chk_samp;
  logic [CNT_W-1:0] chk_eq;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chk_total <= '0;
      chk_samp  <= '0;
      chk_eq    <= '0;
    end else begin
      chk_total <= take ? '0 : (state != ST_IDLE ? chk_total + CNT_W'(1) : chk_total);
      chk_samp  <= take ? '0 : (sampling ? chk_samp + CNT_W'(1) : chk_samp);
      chk_eq    <= take ? '0 : (state == ST_EQUAL ? chk_eq + CNT_W'(1) : chk_eq);
    end
  end

  property p_step_len;
    @(posedge sys_clk) disable iff (!rstn)
      (state == ST_BITS && $past(state) == ST_SAMPLE) |->
        (cnt == ((lat_ccs == CCS_MID) ? CNT_W'(CC_CYC_MID - 1) :
                 (lat_ccs == CCS_SLOW) ? CNT_W'(CC_CYC_SLOW - 1) : CNT_W'(CC_CYC_FAST - 1)));
  endproperty
  a_step_len: assert property (p_step_len) else $error("step length wrong");

  property p_field_pos;
    @(posedge sys_clk) disable iff (!rstn)
      ctrl_wr |=> (ccs_field == $past(ctrl_wdata[CCS_LSB +: SEL_W]) &&
                   scs_field == $past(ctrl_wdata[SCS_LSB +: SEL_W]));
  endproperty
  a_field_pos: assert property (p_field_pos) else $error("select fields misplaced");

  property p_sample_len;
    @(posedge sys_clk) disable iff (!rstn)
      $fell(sampling) |-> (chk_samp == CNT_W'(SAMPLE_SC_PERIODS) * (step_len << lat_scs));
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample length wrong");

  property p_total;
    @(posedge sys_clk) disable iff (!rstn)
      result_valid |-> (chk_total == sample_len + CNT_W'(RES_BITS + EQ_STEPS) * step_len
                                     + CNT_W'(LOAD_CYC));
  endproperty
  a_total: assert property (p_total) else $error("conversion length wrong");

  property p_sample_first;
    @(posedge sys_clk) disable iff (!rstn)
      take |=> (sampling && conv_busy) ##0 (state == ST_SAMPLE)[*2];
  endproperty
  a_sample_first: assert property (p_sample_first) else $error("sampling did not start");

  property p_eq_len;
    @(posedge sys_clk) disable iff (!rstn)
      (state == ST_LOAD && $past(state) == ST_EQUAL) |->
        (chk_eq == CNT_W'(EQ_STEPS) * step_len && step_idx == STEP_W'(EQ_STEPS));
  endproperty
  a_eq_len: assert property (p_eq_len) else $error("equalize length wrong");

  property p_load_end;
    @(posedge sys_clk) disable iff (!rstn)
      $changed(result) |-> (result_valid && $past(state) == ST_LOAD && !conv_busy);
  endproperty
  a_load_end: assert property (p_load_end) else $error("result loaded off time");

  property p_input_frozen;
    @(posedge sys_clk) disable iff (!rstn)
      (state != ST_IDLE && state != ST_SAMPLE && $past(state) != ST_SAMPLE) |->
        ($stable(clamp_lo) && $stable(clamp_hi));
  endproperty
  a_input_frozen: assert property (p_input_frozen) else $error("range flag moved");

  property p_clamp;
    @(posedge sys_clk) disable iff (!rstn)
      result_valid |-> (clamp_lo ? (result == 10'h000) : (!clamp_hi || result == 10'h3ff));
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp code wrong");

endmodule // adcs_conv_timing

/* verif/adcs_conv_timing_tb_top.sv */
// Self-checking bench for the A/D conversion timing sequencer
`timescale 1ns/1ps

module adcs_conv_timing_tb_top;
  import adcs_pkg::*;

  logic                sys_clk = 1'b0;
  logic                rstn = 1'b0;
  logic                ctrl_wr = 1'b0;
  logic [CTRL_W-1:0]   ctrl_wdata = 16'h0000;
  logic                conv_start = 1'b0;
  logic                cmp_below_pin = 1'b0;
  logic                below_gnd_pin = 1'b0;
  logic                above_ref_pin = 1'b0;
  logic [CTRL_W-1:0]   converter_control_reg;
  logic                conv_busy;
  logic                sampling;
  logic [RES_BITS-1:0] dac_code;
  logic [RES_BITS-1:0] result;
  logic                result_valid;
  int                  errors = 0;
  int                  comparisons = 0;
  int                  seed = 32'h43f655c7;
  logic [1:0]          step_codes [3] = '{2'h0, 2'h3, 2'h2};

  adcs_conv_timing adcs_conv_timing_inst (
    .sys_clk               (sys_clk),
    .rstn                  (rstn),
    .ctrl_wr               (ctrl_wr),
    .ctrl_wdata            (ctrl_wdata),
    .conv_start            (conv_start),
    .cmp_below_pin         (cmp_below_pin),
    .below_gnd_pin         (below_gnd_pin),
    .above_ref_pin         (above_ref_pin),
    .converter_control_reg (converter_control_reg),
    .conv_busy             (conv_busy),
    .sampling              (sampling),
    .dac_code              (dac_code),
    .result                (result),
    .result_valid          (result_valid)
  );

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Design values, zero-extended, compared with case equality
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Cycle counts measured by the bench
  task automatic chk_n(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      errors++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // Step period in sys_clk cycles: two half-period units per cycle
  function automatic int step_cycles(input logic [1:0] ccs);
    return (ccs == 2'h3) ? 48 / 2 : (ccs == 2'h2) ? 96 / 2 : 24 / 2;
  endfunction

  task automatic wr_ctrl(input logic [15:0] w);
    ctrl_wdata = w;
    ctrl_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    ctrl_wr = 1'b0;
    chk_v(converter_control_reg, w, "ctrl reg");
  endtask

  // One conversion; chained means start is still held high by the previous call
  task automatic conv(input logic [1:0] ccs, input logic [1:0] ssel, input logic [9:0] a,
                      input bit lo, input bit hi, input bit chained, input bit chain_next);
    int cc, s, exp_k, k, ns;
    logic [9:0] exp_r;
    cc = step_cycles(ccs);
    s = 2 * (cc << ssel);
    exp_k = s + 14 * cc + 4 / 2;
    exp_r = lo ? 10'h000 : (hi ? 10'h3ff : a);
    k = 0;
    ns = 0;
    below_gnd_pin = lo;
    above_ref_pin = hi;
    if (!chained) begin
      wr_ctrl({ccs, ssel, 12'($random(seed))});
      conv_start = 1'b1;
    end
    // Start is taken at this edge in both cases
    @(posedge sys_clk);
    #1;
    while (k < exp_k + 5 && result_valid !== 1'b1) begin
      // Count the sampling level seen in this cycle, before the edge
      ns += int'(sampling === 1'b1);
      // Extra start requests while busy must be ignored
      conv_start = (k < 3) || (chain_next && k == exp_k - 1);
      cmp_below_pin = (a < dac_code);
      if (k == s + 4) begin
        below_gnd_pin = ~lo;
        above_ref_pin = ~hi;
      end
      @(posedge sys_clk);
      #1;
      k++;
      if (k == s + 1) chk_v(dac_code, 16'h0200, "first trial");
    end
    chk_n(k, exp_k, "conversion length");
    chk_n(ns, s, "sampling length");
    chk_v(result, exp_r, "result");
    if (!chain_next) chk_v(conv_busy, 16'h0000, "busy after end");
    conv_start = chain_next;
  endtask

  initial begin
    logic [9:0] a;
    repeat (8) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    chk_v(converter_control_reg, 16'h0000, "reset ctrl");
    chk_v({result_valid, conv_busy, sampling, result}, 16'h0000, "reset outputs");
    // Boundary codes and clamps, both set means below ground wins
    conv(2'h0, 2'h0, 10'h000, 0, 0, 0, 0);
    conv(2'h0, 2'h0, 10'h3ff, 0, 0, 0, 0);
    conv(2'h0, 2'h1, 10'h155, 1, 0, 0, 0);
    conv(2'h3, 2'h0, 10'h0aa, 0, 1, 0, 0);
    conv(2'h0, 2'h0, 10'h2aa, 1, 1, 0, 0);
    // Every code pair, each with a back-to-back follower
    foreach (step_codes[i]) begin
      for (int j = 0; j < 4; j++) begin
        a = 10'($random(seed));
        conv(step_codes[i], 2'(j), a, 0, 0, 0, 1);
        a = 10'($random(seed));
        conv(step_codes[i], 2'(j), a, 0, 0, 1, 0);
      end
    end
    // Random mix with occasional clamps
    repeat (12) begin
      a = 10'($random(seed));
      conv(step_codes[($random(seed) & 32'h7fffffff) % 3], 2'($random(seed)), a,
           ($random(seed) & 7) == 0, ($random(seed) & 7) == 0, 0, 0);
    end
    wrap_up();
  end

  // About 41 conversions of at most 1442 cycles each, with margin
  initial begin
    #(8 * 70000);
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    wrap_up();
  end

endmodule // adcs_conv_timing_tb_top
